// [rcr_regs.vh]
// Constants for the reset cause recorder: register map, flag positions, reset values.
// Included by all design files of the block; holds definitions only.
`ifndef RCR_REGS_VH
`define RCR_REGS_VH
`define RCR_ADDR_CAUSE      4'h0
`define RCR_ADDR_CTRL       4'h4
`define RCR_ADDR_STATE      4'h8
`define RCR_BIT_TRAP        15
`define RCR_BIT_ILLEGAL     14
`define RCR_BIT_CFGMIS      9
`define RCR_BIT_PIN         7
`define RCR_BIT_SOFT        6
`define RCR_BIT_WDOG        4
`define RCR_BIT_SLEEP       3
`define RCR_BIT_IDLE        2
`define RCR_BIT_BROWN       1
`define RCR_BIT_POWER       0
`define RCR_CAUSE_MASK      16'hc2df
`define RCR_CAUSE_POR       16'h0003
`define RCR_BROWN_CLEAR     16'hc25c
`define RCR_RESET_VECTOR    24'h000000
`define RCR_SYSTEM_RESET_SIGNAL_CYCLES   4'h1
`define RCR_NUM_WREG        16
`define RCR_SP_INDEX        4'hf
`endif

// [rcr_wreg_track.v]
// Tracks which working registers were written since the last system reset.
// Assumes core write and pointer-use strobes are on clk_sys.
`timescale 1ns/1ns
`include "rcr_regs.vh"
module rcr_wreg_track
#(
  parameter NUM_WREG = `RCR_NUM_WREG
)
(
  input  wire                clk_sys,
  input  wire                rst,
  input  wire                sys_reset,
  input  wire                wr_en,
  input  wire [3:0]          wr_index,
  input  wire                ptr_use,
  input  wire [3:0]          ptr_index,
  output reg                 uninit_fault,
  output wire [NUM_WREG-1:0] init_map
);
  reg [NUM_WREG-1:0] written;
  reg [NUM_WREG-1:0] next_written;
  integer i;

  // Stack pointer keeps its content, so it is never uninitialised
  always @*
  begin
    next_written = written;
    for (i = 0; i < NUM_WREG; i = i + 1)
    begin
      if (sys_reset)
        next_written[i] = (i == `RCR_SP_INDEX);
      else if (wr_en && (wr_index == i))
        next_written[i] = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      written      <= {{(NUM_WREG-1){1'b0}}, 1'b1} << `RCR_SP_INDEX;
      uninit_fault <= 1'b0;
    end
    else
    begin
      written      <= next_written;
      uninit_fault <= ptr_use && !sys_reset && !written[ptr_index];
    end
  end

  assign init_map = written;
endmodule // rcr_wreg_track

// [rcr_guard.v]
// Checks program and vector flow targets against the protected segment window.
// Assumes pc load strobes and target come from the core on clk_sys.
`timescale 1ns/1ns
`include "rcr_regs.vh"
module rcr_guard
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        protect_en,
  input  wire [23:0] prot_lo,
  input  wire [23:0] prot_hi,
  input  wire        program_flow_change,
  input  wire        vector_flow_change,
  input  wire [23:0] pc_target,
  output reg         security_fault
);
  function in_window;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_window = (a >= lo) && (a <= hi);
    end
  endfunction

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      security_fault <= 1'b0;
    else
      security_fault <= protect_en && (program_flow_change || vector_flow_change)
                        && in_window(pc_target, prot_lo, prot_hi);
  end
endmodule // rcr_guard

// [rcr_top.v]
// Reset cause recorder: cause flags, system reset pulse, PC restart, AXI4-Lite slave.
// Assumes rst is the power-on reset; brown-out and pin reset arrive asynchronously.
//
// Summary of operation
// - Pointer use of an unwritten working register raises a device reset.
// - Reset clears working registers except stack pointer; they count as unwritten.
// - Flow change into protected segment raises a security reset.
// - Program flow change is any branch, call, jump or return reload of PC.
// - Vector flow change is a PC reload with interrupt or trap vector.
// - Bit 15 set by trap conflict, cleared by power-on or brown-out.
// - Bit 14 set by illegal opcode, unwritten register or security reset.
// - Bit 9 set by configuration mismatch, cleared by power-on or brown-out.
// - Bit 7 set by reset pin, cleared only by power-on.
// - Bit 6 set by software reset instruction, cleared by power-on or brown-out.
// - Bit 4 set by watchdog; cleared by power-save, watchdog clear, power-on, brown-out.
// - Bit 3 set on power-save into sleep.
// - Bit 2 set on power-save into idle.
// - Bit 1 set by power-on and brown-out, never cleared by hardware.
// - Software may set or clear every flag directly.
// - Any reset clears registers, zeroes PC, fetches from address zero.
// - Software reset keeps clock, releases system reset next cycle.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rcr_regs.vh"
module rcr_top
(
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        brownout_reset,
  input  wire        external_reset_pin_n,
  input  wire        trap_conflict,
  input  wire        illegal_opcode,
  input  wire        config_mismatch,
  input  wire        soft_reset_instr,
  input  wire        watchdog_timeout,
  input  wire        power_save_instruction,
  input  wire        power_save_sleep,
  input  wire        watchdog_clear_instruction,
  input  wire        wreg_wr_en,
  input  wire [3:0]  wreg_wr_index,
  input  wire        wreg_ptr_use,
  input  wire [3:0]  wreg_ptr_index,
  input  wire        program_flow_change,
  input  wire        vector_flow_change,
  input  wire [23:0] pc_target,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         system_reset_signal,
  output reg         pc_load,
  output reg  [23:0] pc_reset_value,
  output reg         core_clear,
  output reg         keep_clock
);
  localparam ST_RUN   = 2'h0;
  localparam ST_HOLD  = 2'h1;
  localparam ST_FETCH = 2'h2;

  reg [1:0]  brown_sync;
  reg [1:0]  pin_sync;
  reg        brown_prev;
  reg        pin_prev;
  reg [15:0] reset_cause_status;
  reg [15:0] next_cause;
  reg        protect_en;
  reg [23:0] prot_lo;
  reg [23:0] prot_hi;
  reg [1:0]  state;
  reg        soft_only;
  reg [31:0] aw_addr;
  reg        aw_have;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        w_have;
  wire       uninit_fault;
  wire       security_fault;
  wire [15:0] init_map;
  wire       brown_evt;
  wire       pin_evt;
  wire       any_reset;
  wire       wr_go;

  assign brown_evt = brown_sync[1] && !brown_prev;
  assign pin_evt   = pin_sync[1] && !pin_prev;
  assign any_reset = brown_evt || pin_evt || trap_conflict || illegal_opcode
                     || uninit_fault || security_fault || config_mismatch
                     || soft_reset_instr || watchdog_timeout;
  assign wr_go     = aw_have && w_have && !s_axi_bvalid;

  rcr_wreg_track u_track
  (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .sys_reset    (system_reset_signal),
    .wr_en        (wreg_wr_en),
    .wr_index     (wreg_wr_index),
    .ptr_use      (wreg_ptr_use),
    .ptr_index    (wreg_ptr_index),
    .uninit_fault (uninit_fault),
    .init_map     (init_map)
  );

  rcr_guard u_guard
  (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .protect_en          (protect_en),
    .prot_lo             (prot_lo),
    .prot_hi             (prot_hi),
    .program_flow_change (program_flow_change),
    .vector_flow_change  (vector_flow_change),
    .pc_target           (pc_target),
    .security_fault      (security_fault)
  );

  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge = old;
      if (strb[0])
        merge[7:0] = data[7:0];
      if (strb[1])
        merge[15:8] = data[15:8];
      merge = merge & `RCR_CAUSE_MASK;
    end
  endfunction

  // Software write first, hardware sets and clears after, so sets win
  always @*
  begin
    next_cause = reset_cause_status;
    if (wr_go && (aw_addr == {28'h0, `RCR_ADDR_CAUSE}))
      next_cause = merge(reset_cause_status, w_data, w_strb);
    if (brown_evt)
    begin
      next_cause = next_cause & ~`RCR_BROWN_CLEAR;
      next_cause[`RCR_BIT_BROWN] = 1'b1;
    end
    if (power_save_instruction || watchdog_clear_instruction)
      next_cause[`RCR_BIT_WDOG] = 1'b0;
    // All sources checked independently, not priority encoded
    if (trap_conflict)
      next_cause[`RCR_BIT_TRAP] = 1'b1;
    if (illegal_opcode || uninit_fault || security_fault)
      next_cause[`RCR_BIT_ILLEGAL] = 1'b1;
    if (config_mismatch)
      next_cause[`RCR_BIT_CFGMIS] = 1'b1;
    if (pin_evt)
      next_cause[`RCR_BIT_PIN] = 1'b1;
    if (soft_reset_instr)
      next_cause[`RCR_BIT_SOFT] = 1'b1;
    if (watchdog_timeout)
      next_cause[`RCR_BIT_WDOG] = 1'b1;
    if (power_save_instruction && power_save_sleep)
      next_cause[`RCR_BIT_SLEEP] = 1'b1;
    if (power_save_instruction && !power_save_sleep)
      next_cause[`RCR_BIT_IDLE] = 1'b1;
  end

  // Pin is active low; both go through two flops before any edge logic
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      brown_sync <= 2'h0;
      pin_sync   <= 2'h0;
      brown_prev <= 1'b0;
      pin_prev   <= 1'b0;
    end
    else
    begin
      brown_sync <= {brown_sync[0], brownout_reset};
      pin_sync   <= {pin_sync[0], !external_reset_pin_n};
      brown_prev <= brown_sync[1];
      pin_prev   <= pin_sync[1];
    end
  end

  // Power-on clears everything and sets both power flags
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reset_cause_status <= `RCR_CAUSE_POR;
    else
      reset_cause_status <= next_cause;
  end

  // Reset sequencer: one-cycle system reset, then PC forced to zero
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state               <= ST_HOLD;
      soft_only           <= 1'b0;
      system_reset_signal <= 1'b1;
      core_clear          <= 1'b1;
      pc_load             <= 1'b0;
      pc_reset_value      <= `RCR_RESET_VECTOR;
      keep_clock          <= 1'b0;
    end
    else
    begin
      pc_reset_value <= `RCR_RESET_VECTOR;
      case (state)
        ST_RUN:
        begin
          pc_load <= 1'b0;
          if (any_reset)
          begin
            state               <= ST_HOLD;
            system_reset_signal <= 1'b1;
            core_clear          <= 1'b1;
            soft_only           <= soft_reset_instr && !brown_evt;
            keep_clock          <= soft_reset_instr && !brown_evt;
          end
        end
        ST_HOLD:
        begin
          // Released after one cycle; the fetch starts the cycle after
          state               <= ST_FETCH;
          system_reset_signal <= 1'b0;
          core_clear          <= 1'b0;
        end
        ST_FETCH:
        begin
          state      <= ST_RUN;
          pc_load    <= 1'b1;
          keep_clock <= soft_only;
        end
        default:
        begin
          state               <= ST_RUN;
          system_reset_signal <= 1'b0;
          core_clear          <= 1'b0;
          pc_load             <= 1'b0;
        end
      endcase
    end
  end

  // AXI4-Lite: address and data held until both present, one write at a time
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 32'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      protect_en    <= 1'b0;
      prot_lo       <= 24'h0;
      prot_hi       <= 24'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (aw_addr == {28'h0, `RCR_ADDR_CTRL})
        begin
          if (w_strb[0])
            protect_en <= w_data[0];
        end
        else if (aw_addr == {28'h0, `RCR_ADDR_STATE})
        begin
          if (w_strb[2])
            prot_lo <= w_data[23:0];
          if (w_strb[3])
            prot_hi <= {w_data[31:24], w_data[15:0]};
        end
        else if (aw_addr[31:4] != 28'h0 || aw_addr[3:0] != `RCR_ADDR_CAUSE)
          s_axi_bresp <= 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      if (s_axi_araddr[31:4] != 28'h0)
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
      else if (s_axi_araddr[3:0] == `RCR_ADDR_CAUSE)
        s_axi_rdata <= {16'h0, reset_cause_status};
      else if (s_axi_araddr[3:0] == `RCR_ADDR_CTRL)
        s_axi_rdata <= {31'h0, protect_en};
      else if (s_axi_araddr[3:0] == `RCR_ADDR_STATE)
        s_axi_rdata <= {16'h0, init_map};
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // rcr_top

// [rcr_checker.sv]
// Checker for rcr_top: restart sequence after resets and AXI answers.
// Assumes one clk_sys domain; rst is the power-on reset.
`timescale 1ns/1ns
module rcr_checker
(
  input wire        clk_sys,
  input wire        rst,
  input wire        soft_reset_instr,
  input wire        trap_conflict,
  input wire        system_reset_signal,
  input wire        core_clear,
  input wire        pc_load,
  input wire [23:0] pc_reset_value,
  input wire        keep_clock,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  pc_zero_a: assert property (pc_load |-> pc_reset_value == 24'h000000)
    else $error("pc reload value not zero");
  pc_restart_a: assert property ($fell(system_reset_signal) |=> pc_load)
    else $error("no pc reload after reset release");
  pc_pulse_a: assert property (pc_load |=> !pc_load)
    else $error("pc reload longer than one cycle");
  core_clear_a: assert property (system_reset_signal |-> core_clear)
    else $error("core not cleared during reset");
  soft_release_a: assert property
    (soft_reset_instr |=> system_reset_signal ##1 !system_reset_signal)
    else $error("soft reset not released next cycle");
  keep_clk_a: assert property (soft_reset_instr |=> keep_clock)
    else $error("clock source not kept on soft reset");
  trap_rst_a: assert property (trap_conflict |=> system_reset_signal)
    else $error("trap conflict raised no reset");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  rd_slverr_a: assert property
    (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h8 |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule // rcr_checker

bind rcr_top rcr_checker u_rcr_checker (.clk_sys, .rst, .soft_reset_instr, .trap_conflict,
  .system_reset_signal, .core_clear, .pc_load, .pc_reset_value, .keep_clock, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_bvalid,
  .s_axi_awready, .s_axi_wready);

// [rcr_core_model.sv]
// Core and reset-source stand-in: turns a bench event mask into core strobes.
// Assumes each mask bit is held for one clk_sys cycle per event.
`timescale 1ns/1ns
module rcr_core_model
(
  input  wire        clk_sys,
  input  wire [11:0] ev,
  input  wire [3:0]  idx,
  input  wire [23:0] tgt,
  output reg         trap_conflict = 1'b0,
  output reg         illegal_opcode = 1'b0,
  output reg         config_mismatch = 1'b0,
  output reg         soft_reset_instr = 1'b0,
  output reg         watchdog_timeout = 1'b0,
  output reg         power_save_instruction = 1'b0,
  output reg         power_save_sleep = 1'b0,
  output reg         watchdog_clear_instruction = 1'b0,
  output reg         wreg_wr_en = 1'b0,
  output reg  [3:0]  wreg_wr_index = 4'h0,
  output reg         wreg_ptr_use = 1'b0,
  output reg  [3:0]  wreg_ptr_index = 4'h0,
  output reg         program_flow_change = 1'b0,
  output reg         vector_flow_change = 1'b0,
  output reg  [23:0] pc_target = 24'h000000
);
  always @(posedge clk_sys)
  begin
    {vector_flow_change, program_flow_change} <= ev[11:10];
    {wreg_ptr_use, wreg_wr_en, watchdog_clear_instruction} <= ev[9:7];
    power_save_instruction <= |ev[6:5];
    {watchdog_timeout, soft_reset_instr, config_mismatch} <= ev[4:2];
    {illegal_opcode, trap_conflict} <= ev[1:0];
    // Unqualified lines toggle, so a stale value is never mistaken for a real one
    power_save_sleep <= |ev[6:5] ? ev[5] : ~power_save_sleep;
    wreg_wr_index <= ev[8] ? idx : ~wreg_wr_index;
    wreg_ptr_index <= ev[9] ? idx : ~wreg_ptr_index;
    pc_target <= |ev[11:10] ? tgt : ~pc_target;
  end
endmodule // rcr_core_model

// [reset_cause_recorder_bench.sv]
// Self-checking bench for rcr_top: AXI4-Lite master, core events, cause checks.
// Assumes rcr_core_model and rcr_checker are compiled before it.
`timescale 1ns/1ns
module reset_cause_recorder_bench;
  localparam [111:0] FL = {16'h0004, 16'h0008, 16'h0010, 16'h0040, 16'h0200, 16'h4000, 16'h8000};
  localparam [71:0]  TG = {24'h011000, 24'h020000, 24'h002000};
  reg         clk_sys = 1'b0, rst = 1'b1, brownout_reset = 1'b0, external_reset_pin_n = 1'b1;
  reg  [11:0] ev = 12'h000;
  reg  [3:0]  idx = 4'h0, s_axi_wstrb = 4'h0;
  reg  [23:0] tgt = 24'h000000;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, r;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire        trap_conflict, illegal_opcode, config_mismatch, soft_reset_instr;
  wire        watchdog_timeout, power_save_instruction, power_save_sleep;
  wire        watchdog_clear_instruction, wreg_wr_en, wreg_ptr_use;
  wire        program_flow_change, vector_flow_change, pc_load, core_clear, keep_clock;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        system_reset_signal;
  wire [3:0]  wreg_wr_index, wreg_ptr_index;
  wire [23:0] pc_target, pc_reset_value;
  wire [31:0] s_axi_rdata;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  reg  [33:0] exp_q[$];
  reg  [1:0]  expb_q[$];
  integer     error_cnt = 0, n_compared = 0, seed = 76, i, k;

  rcr_core_model u_rcr_core_model (.clk_sys, .ev, .idx, .tgt, .trap_conflict, .illegal_opcode,
    .config_mismatch, .soft_reset_instr, .watchdog_timeout, .power_save_instruction,
    .power_save_sleep, .watchdog_clear_instruction, .wreg_wr_en, .wreg_wr_index,
    .wreg_ptr_use, .wreg_ptr_index, .program_flow_change, .vector_flow_change, .pc_target);
  rcr_top u_rcr_top (.clk_sys, .rst, .brownout_reset, .external_reset_pin_n, .trap_conflict,
    .illegal_opcode, .config_mismatch, .soft_reset_instr, .watchdog_timeout,
    .power_save_instruction, .power_save_sleep, .watchdog_clear_instruction, .wreg_wr_en,
    .wreg_wr_index, .wreg_ptr_use, .wreg_ptr_index, .program_flow_change,
    .vector_flow_change, .pc_target, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .system_reset_signal, .pc_load,
    .pc_reset_value, .core_clear, .keep_clock);

  initial forever #2 clk_sys = ~clk_sys;

  task chk(input [33:0] s, input [33:0] e, input string nm);
    begin
      n_compared = n_compared + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
    end
  endtask

  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Bounded wait: a missing answer ends the run instead of hanging
  task tmo;
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] handshake exp 1 got 0");
      results;
    end
  endtask

  task wr(input [31:0] a, input [3:0] st, input [31:0] d);
    begin
      expb_q.push_back(a > 32'h8 ? 2'b10 : 2'b00);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (k = 0; k < 99; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) k = 200;
      end
      if (k < 200) tmo;
    end
  endtask

  task rd(input [31:0] a, input [1:0] rs, input [15:0] d);
    begin
      exp_q.push_back({rs, 16'h0000, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (k = 0; k < 99; k = k + 1)
      begin
        @(posedge clk_sys);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) k = 200;
      end
      if (k < 200) tmo;
    end
  endtask

  task pulse(input [11:0] m);
    begin
      ev <= m;
      @(posedge clk_sys);
      ev <= 12'h000;
      repeat (8) @(posedge clk_sys);
    end
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  always @(posedge clk_sys)
  begin
    if (s_axi_rvalid === 1'b1 && exp_q.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front(), "rresp_rdata");
    if (s_axi_bvalid === 1'b1 && expb_q.size() > 0)
      chk({32'h0, s_axi_bresp}, {32'h0, expb_q.pop_front()}, "bresp");
  end

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(32'h0, 2'b00, 16'h0003);
    for (i = 0; i < 7; i = i + 1)
    begin
      pulse(12'h001 << i);
      rd(32'h0, 2'b00, 16'h0003 | FL[i*16 +: 16]);
      wr(32'h0, 4'h3, 32'h3);
    end
    done("event flags");
    idx <= 4'h5;
    pulse(12'h100);
    pulse(12'h200);
    rd(32'h8, 2'b00, 16'h8020);
    idx <= 4'hf;
    pulse(12'h200);
    rd(32'h0, 2'b00, 16'h0003);
    idx <= 4'h3;
    pulse(12'h200);
    rd(32'h0, 2'b00, 16'h4003);
    rd(32'h8, 2'b00, 16'h8000);
    wr(32'h0, 4'h3, 32'h3);
    done("working registers");
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(32'h8, 4'hc, 32'h01001000);
      wr(32'h4, 4'h1, 32'h1);
      tgt <= TG[i*24 +: 24];
      pulse(i ? 12'h800 : 12'h400);
      rd(32'h0, 2'b00, i == 1 ? 16'h0003 : 16'h4003);
      wr(32'h0, 4'h3, 32'h3);
    end
    done("protected segment");
    pulse(12'h005);
    rd(32'h0, 2'b00, 16'h8203);
    wr(32'h0, 4'h3, 32'h3);
    pulse(12'h010);
    pulse(12'h080);
    rd(32'h0, 2'b00, 16'h0003);
    pulse(12'h010);
    pulse(12'h040);
    rd(32'h0, 2'b00, 16'h0007);
    done("watchdog");
    wr(32'h0, 4'h1, 32'hffff);
    rd(32'h0, 2'b00, 16'h00df);
    repeat (4)
    begin
      r = $random(seed);
      wr(32'h0, 4'h3, r);
      rd(32'h0, 2'b00, r[15:0] & 16'hc2df);
    end
    wr(32'h10, 4'hf, 32'hffff);
    rd(32'h10, 2'b10, 16'h0000);
    rd(32'h0, 2'b00, r[15:0] & 16'hc2df);
    done("software access");
    wr(32'h0, 4'h3, 32'h3);
    external_reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    external_reset_pin_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(32'h0, 2'b00, 16'h0083);
    wr(32'h0, 4'h3, 32'hc2de);
    brownout_reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    brownout_reset <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(32'h0, 2'b00, 16'h0082);
    wr(32'h0, 4'h3, 32'hffff);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(32'h0, 2'b00, 16'h0003);
    done("pin brown-out power-on");
    @(posedge clk_sys);
    results;
  end
endmodule // reset_cause_recorder_bench
